// File: src/dmx_engine.sv
// Summary of operation
// - Block or repeat mode: low size half counts down once per transfer.
// - A low half at one (or zero) reloads from the programmed upper half instead of counting down.
// - Hardware never changes the upper size half.
// - Enable clears on completion, escape events, errors, reset, standby, software zero.
// - Active reads one only while the channel owns a transfer.
// - In block mode a zero enable write lets the block finish.
// - In burst mode at most three transfers follow a zero enable write.
// - Address error or NMI clears every enable and sets channel 0 error flag.
// - In module stop the error flag is left unchanged.
// - Escape events set the escape flag; with its enable it requests.
// - Escape flag sets only after the bus cycle ends and active drops.
// - Writing enable one clears the escape flag.
// - Full count completion sets the completion flag with the same timing.
// - Writing enable one clears the completion flag.
// - Fixed priority, channel 0 highest, start only once the bus is free.
// - Another bus master runs at the next release point.
// - No channel switch inside a burst or a block.
// - Each unit is a read then a write with no release between.
// - Cycle steal releases the bus after every unit.
// - Burst runs units back to back until an end condition.
// - Block mode moves one whole block per request, then releases.
// - Byte count drops by 1, 2, 4 or 8; zero means uncounted.
// Purpose: status, control and bus use of a four-channel DMA engine.
// Assumes: events, requests and cyc_done come from logic on core_clk.
// Notes: register reads answer in the next cycle; unmapped reads give zero.
`default_nettype none
module dmx_engine (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [dmx_pkg::DMX_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [dmx_pkg::DMX_NCH-1:0] xfer_req,
	input wire logic [dmx_pkg::DMX_NCH-1:0] esc_evt,
	input wire logic nmi_evt,
	input wire logic addr_err_evt,
	input wire logic hw_standby,
	input wire logic module_stop,
	input wire logic other_req,
	input wire logic cyc_done,
	output logic cyc_req,
	output logic cyc_write,
	output logic [1:0] cyc_ch,
	output logic [1:0] cyc_size,
	output logic [dmx_pkg::DMX_NCH-1:0] esc_irq,
	output logic [dmx_pkg::DMX_NCH-1:0] end_irq
);
	import dmx_pkg::*;

	dmx_state_t state_reg, state_next;
	logic [1:0] cur_reg, cur_next;
	logic [1:0] drain_reg, drain_next;
	logic halt_reg, halt_next, end_esc_reg, end_esc_next, end_tot_reg, end_tot_next;
	logic err_pend_reg, err_pend_next, system_error_flag_reg, system_error_flag_next;
	logic [31:0] rdata_reg, rdata_next;

	logic [DMX_NCH-1:0] en_reg, en_next;
	logic [DMX_NCH-1:0] escape_flag_reg, escape_flag_next;
	logic [DMX_NCH-1:0] completion_flag_reg, completion_flag_next;
	logic [DMX_NCH-1:0] escape_interrupt_enable_reg, escape_interrupt_enable_next;
	logic [DMX_NCH-1:0] completion_interrupt_enable_reg, completion_interrupt_enable_next;
	logic [DMX_NCH-1:0] escp_reg, escp_next;
	logic [1:0] xm_reg [DMX_NCH], xm_next [DMX_NCH];
	logic [1:0] dsz_reg [DMX_NCH], dsz_next [DMX_NCH];
	logic [31:0] size_reg [DMX_NCH], size_next [DMX_NCH];
	logic [31:0] count_reg [DMX_NCH], count_next [DMX_NCH];

	logic [DMX_NCH-1:0] wr_size, wr_mode, wr_count, act, step_here, gap_here;
	logic in_map, sys_err, busy, unit_done, stop_unit, cont;
	logic [1:0] sel_ch;
	logic [3:0] ofs;
	dmx_xmode_t xm_cur;
	logic [31:0] su_size, su_count;
	logic su_blk_end, su_tot_end, blk_on;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	dmx_arb_if arb ();
	dmx_arbiter u_arb (
		.arb_io(arb.arb)
	);

	// Address decode
	assign sel_ch = reg_addr[5:4];
	assign ofs = reg_addr[3:0];
	assign in_map = (reg_addr[DMX_AW-1:6] == '0);
	assign sys_err = nmi_evt | addr_err_evt;
	assign busy = (state_reg == ST_READ) || (state_reg == ST_WRITE);
	assign unit_done = (state_reg == ST_WRITE) && cyc_done;
	assign xm_cur = dmx_xmode_t'(xm_reg[cur_reg]);
	assign blk_on = (xm_cur == XM_BLOCK) || (xm_cur == XM_REPEAT);

	dmx_unit_step u_step (
		.size_cur(size_reg[cur_reg]),
		.count_cur(count_reg[cur_reg]),
		.dsz(dsz_reg[cur_reg]),
		.blk_on(blk_on),
		.size_nxt(su_size),
		.count_nxt(su_count),
		.blk_end(su_blk_end),
		.tot_end(su_tot_end)
	);

	// Errors and escapes end the run at the close of the current unit
	assign stop_unit = su_tot_end | escp_reg[cur_reg] | err_pend_reg | sys_err;

	// Other masters only get in while the engine sits idle
	assign arb.pend = en_reg & xfer_req;
	assign arb.grant_ok = (state_reg == ST_IDLE) && !other_req;
	genvar gi;
	generate
		for (gi = 0; gi < DMX_NCH; gi++) begin : g_ch
			assign wr_size[gi] = reg_wr && in_map && sel_ch == 2'(gi) && ofs == OFS_SIZE;
			assign wr_mode[gi] = reg_wr && in_map && sel_ch == 2'(gi) && ofs == OFS_MODE;
			assign wr_count[gi] = reg_wr && in_map && sel_ch == 2'(gi) && ofs == OFS_COUNT;
			assign act[gi] = busy && cur_reg == 2'(gi);
			assign step_here[gi] = unit_done && cur_reg == 2'(gi);
			assign gap_here[gi] = (state_reg == ST_GAP) && cur_reg == 2'(gi);
			assign esc_irq[gi] = escape_flag_reg[gi] & escape_interrupt_enable_reg[gi];
			assign end_irq[gi] = completion_flag_reg[gi] & completion_interrupt_enable_reg[gi];

			always_comb begin
				en_next[gi] = en_reg[gi];
				escape_flag_next[gi] = escape_flag_reg[gi];
				completion_flag_next[gi] = completion_flag_reg[gi];
				escape_interrupt_enable_next[gi] = escape_interrupt_enable_reg[gi];
				completion_interrupt_enable_next[gi] = completion_interrupt_enable_reg[gi];
				xm_next[gi] = xm_reg[gi];
				dsz_next[gi] = dsz_reg[gi];
				escp_next[gi] = escp_reg[gi];
				size_next[gi] = size_reg[gi];
				count_next[gi] = count_reg[gi];
				if (wr_mode[gi]) begin
					en_next[gi] = reg_wdata[B_EN];
					escape_interrupt_enable_next[gi] = reg_wdata[B_ESCAPE_INTERRUPT_ENABLE];
					completion_interrupt_enable_next[gi] = reg_wdata[B_COMPLETION_INTERRUPT_ENABLE];
					xm_next[gi] = reg_wdata[F_XM_LO +: 2];
					dsz_next[gi] = reg_wdata[F_DSZ_LO +: 2];
					if (reg_wdata[B_EN]) begin
						escape_flag_next[gi] = 1'b0;
						completion_flag_next[gi] = 1'b0;
					end
				end
				if (wr_size[gi]) begin
					size_next[gi] = reg_wdata;
				end else if (step_here[gi]) begin
					size_next[gi] = su_size;
				end
				if (wr_count[gi]) begin
					count_next[gi] = reg_wdata;
				end else if (step_here[gi]) begin
					count_next[gi] = su_count;
				end
				// Escape requests only count while this channel owns the bus
				if (esc_evt[gi] && act[gi]) begin
					escp_next[gi] = 1'b1;
				end
				if (gap_here[gi]) begin
					escp_next[gi] = 1'b0;
				end
				// Flags set one cycle after the last bus cycle, with active low
				if (gap_here[gi] && end_esc_reg) begin
					escape_flag_next[gi] = 1'b1;
				end
				if (gap_here[gi] && end_tot_reg) begin
					completion_flag_next[gi] = 1'b1;
				end
				if (step_here[gi] && (su_tot_end || escp_reg[gi])) begin
					en_next[gi] = 1'b0;
				end
				if (sys_err || hw_standby) begin
					en_next[gi] = 1'b0;
				end
			end

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					en_reg[gi] <= 1'b0;
					escape_flag_reg[gi] <= 1'b0;
					completion_flag_reg[gi] <= 1'b0;
					escape_interrupt_enable_reg[gi] <= 1'b0;
					completion_interrupt_enable_reg[gi] <= 1'b0;
					escp_reg[gi] <= 1'b0;
					xm_reg[gi] <= RST_XM;
					dsz_reg[gi] <= RST_DSZ;
					size_reg[gi] <= RST_SIZE;
					count_reg[gi] <= RST_COUNT;
				end else begin
					en_reg[gi] <= en_next[gi];
					escape_flag_reg[gi] <= escape_flag_next[gi];
					completion_flag_reg[gi] <= completion_flag_next[gi];
					escape_interrupt_enable_reg[gi] <= escape_interrupt_enable_next[gi];
					completion_interrupt_enable_reg[gi] <= completion_interrupt_enable_next[gi];
					escp_reg[gi] <= escp_next[gi];
					xm_reg[gi] <= xm_next[gi];
					dsz_reg[gi] <= dsz_next[gi];
					size_reg[gi] <= size_next[gi];
					count_reg[gi] <= count_next[gi];
				end
			end

			chk_upper_half_hold: assert property (!wr_size[gi] |=> $stable(size_reg[gi][31:16]))
				else $error("upper size half changed by hardware");
			chk_size_reload: assert property (step_here[gi] && blk_on
				&& size_reg[gi][15:0] <= 16'h1 && !wr_size[gi]
				|=> size_reg[gi][15:0] == size_reg[gi][31:16])
				else $error("size counter did not reload");
			chk_esc_after_idle: assert property ($rose(escape_flag_reg[gi]) |-> !act[gi])
				else $error("escape flag set while active");
			chk_resume_clears: assert property (wr_mode[gi] && reg_wdata[B_EN]
				&& state_reg != ST_GAP |=> !escape_flag_reg[gi] && !completion_flag_reg[gi])
				else $error("resume did not clear flags");
		end
	endgenerate

	// Channel 0 error flag; software may only clear it
	always_comb begin
		system_error_flag_next = system_error_flag_reg;
		if (wr_mode[0] && !reg_wdata[B_SYSTEM_ERROR_FLAG]) begin
			system_error_flag_next = 1'b0;
		end
		if (sys_err && !module_stop) begin
			system_error_flag_next = 1'b1;
		end
	end

	// Engine sequencing
	always_comb begin
		state_next = state_reg;
		cur_next = cur_reg;
		halt_next = halt_reg;
		drain_next = drain_reg;
		end_esc_next = end_esc_reg;
		end_tot_next = end_tot_reg;
		err_pend_next = err_pend_reg | (sys_err & busy);
		cont = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (arb.hit) begin
					cur_next = arb.sel;
					state_next = ST_READ;
				end
			end
			ST_READ: begin
				if (cyc_done) begin
					state_next = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (cyc_done) begin
					unique case (xm_cur)
						XM_BURST: cont = !stop_unit && !(halt_reg && drain_reg <= 2'h1);
						XM_BLOCK: cont = !stop_unit && !su_blk_end;
						default: cont = 1'b0;
					endcase
					if (halt_reg && drain_reg != 2'h0) begin
						drain_next = drain_reg - 2'h1;
					end
					state_next = cont ? ST_READ : ST_GAP;
					end_esc_next = escp_reg[cur_reg];
					end_tot_next = su_tot_end;
				end
			end
			ST_GAP: begin
				// One released cycle lets any other master in
				state_next = ST_IDLE;
				halt_next = 1'b0;
				err_pend_next = 1'b0;
				end_esc_next = 1'b0;
				end_tot_next = 1'b0;
			end
		endcase
		if (busy && xm_cur == XM_BURST && !halt_reg && wr_mode[cur_reg] && !reg_wdata[B_EN]) begin
			halt_next = 1'b1;
			drain_next = BURST_DRAIN;
		end
	end

	// Read answer, one cycle after the strobe
	always_comb begin
		rdata_next = 32'h0;
		if (reg_rd && in_map) begin
			unique case (ofs)
				OFS_SIZE: rdata_next = size_reg[sel_ch];
				OFS_COUNT: rdata_next = count_reg[sel_ch];
				OFS_MODE: begin
					rdata_next[B_EN] = en_reg[sel_ch];
					rdata_next[B_ACT] = act[sel_ch];
					rdata_next[B_SYSTEM_ERROR_FLAG] = (sel_ch == 2'h0) & system_error_flag_reg;
					rdata_next[B_ESCAPE_FLAG] = escape_flag_reg[sel_ch];
					rdata_next[B_ESCAPE_INTERRUPT_ENABLE] = escape_interrupt_enable_reg[sel_ch];
					rdata_next[B_COMPLETION_FLAG] = completion_flag_reg[sel_ch];
					rdata_next[B_COMPLETION_INTERRUPT_ENABLE] = completion_interrupt_enable_reg[sel_ch];
					rdata_next[F_XM_LO +: 2] = xm_reg[sel_ch];
					rdata_next[F_DSZ_LO +: 2] = dsz_reg[sel_ch];
				end
				default: rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cur_reg <= 2'h0;
			halt_reg <= 1'b0;
			drain_reg <= 2'h0;
			end_esc_reg <= 1'b0;
			end_tot_reg <= 1'b0;
			err_pend_reg <= 1'b0;
			system_error_flag_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			state_reg <= state_next;
			cur_reg <= cur_next;
			halt_reg <= halt_next;
			drain_reg <= drain_next;
			end_esc_reg <= end_esc_next;
			end_tot_reg <= end_tot_next;
			err_pend_reg <= err_pend_next;
			system_error_flag_reg <= system_error_flag_next;
			rdata_reg <= rdata_next;
		end
	end

	// Request stays high across read and write, so the bus is never yielded mid-unit
	assign cyc_req = busy;
	assign cyc_write = (state_reg == ST_WRITE);
	assign cyc_ch = cur_reg;
	assign cyc_size = dsz_reg[cur_reg];
	assign reg_rdata = rdata_reg;

	chk_err_clears_all: assert property (sys_err |=> en_reg == '0)
		else $error("error left a channel enabled");
	chk_system_error_flag_set: assert property (sys_err && !module_stop |=> system_error_flag_reg)
		else $error("error flag not set");
	chk_system_error_flag_stopped: assert property (sys_err && module_stop && !system_error_flag_reg
		&& !(wr_mode[0]) |=> !system_error_flag_reg)
		else $error("error flag set in module stop");
	chk_read_then_write: assert property (state_reg == ST_READ && cyc_done
		|=> state_reg == ST_WRITE && cyc_req)
		else $error("read not followed by write");
	chk_steal_release: assert property (unit_done && xm_cur == XM_STEAL
		|=> state_reg == ST_GAP && !cyc_req ##1 state_reg == ST_IDLE)
		else $error("cycle steal kept the bus");
	chk_fixed_prio: assert property (arb.hit
		|-> (arb.pend & ((4'h1 << arb.sel) - 4'h1)) == 4'h0)
		else $error("lower priority channel granted");
	chk_other_master: assert property (state_reg == ST_IDLE && other_req
		|=> state_reg == ST_IDLE)
		else $error("bus taken from another master");
	chk_block_holds: assert property (unit_done && xm_cur == XM_BLOCK && !su_blk_end
		&& !stop_unit |=> state_reg == ST_READ && $stable(cur_reg))
		else $error("block interrupted");
	chk_burst_drain: assert property (halt_reg && unit_done && drain_reg <= 2'h1
		|=> state_reg == ST_GAP)
		else $error("burst ran past drain");

	cov_burst_run: cover property (unit_done && xm_cur == XM_BURST ##1 state_reg == ST_READ);
	cov_block_end: cover property (unit_done && xm_cur == XM_BLOCK && su_blk_end);
	cov_escape: cover property (state_reg == ST_GAP && end_esc_reg);
	cov_error: cover property (sys_err && busy);
endmodule : dmx_engine
`default_nettype wire

// File: src/dmx_pkg.sv
// Purpose: shared constants and types of the four-channel DMA engine.
// Assumes: one clock, registers reached over a plain strobe port.
// Notes: channel registers sit at a 16-byte stride.
`default_nettype none
package dmx_pkg;
	localparam int DMX_NCH = 4;
	localparam int DMX_AW = 8;
	// Register offsets inside a channel window
	localparam logic [3:0] OFS_SIZE = 4'h0;
	localparam logic [3:0] OFS_MODE = 4'h4;
	localparam logic [3:0] OFS_COUNT = 4'h8;
	// Field positions of channel_mode_control_status
	localparam int B_EN = 0;
	localparam int B_ACT = 1;
	localparam int B_SYSTEM_ERROR_FLAG = 2;
	localparam int B_ESCAPE_FLAG = 3;
	localparam int B_ESCAPE_INTERRUPT_ENABLE = 4;
	localparam int B_COMPLETION_FLAG = 5;
	localparam int B_COMPLETION_INTERRUPT_ENABLE = 6;
	localparam int F_XM_LO = 8;
	localparam int F_DSZ_LO = 10;
	// Reset values
	localparam logic [31:0] RST_SIZE = 32'h0000_0000;
	localparam logic [31:0] RST_COUNT = 32'h0000_0000;
	localparam logic [1:0] RST_XM = 2'h0;
	localparam logic [1:0] RST_DSZ = 2'h0;
	// Transfers allowed after a burst is told to stop
	localparam logic [1:0] BURST_DRAIN = 2'h3;
	typedef enum logic [1:0] {
		XM_STEAL = 2'h0,
		XM_BURST = 2'h1,
		XM_BLOCK = 2'h2,
		XM_REPEAT = 2'h3
	} dmx_xmode_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_WRITE = 4'h4,
		ST_GAP = 4'h8
	} dmx_state_t;
endpackage : dmx_pkg
`default_nettype wire

// File: src/dmx_arb_if.sv
// Purpose: request and grant bundle between engine and arbiter.
// Assumes: combinational grant, sampled by the engine in its idle state.
// Notes: none.
`default_nettype none
interface dmx_arb_if;
	logic [dmx_pkg::DMX_NCH-1:0] pend;
	logic grant_ok;
	logic hit;
	logic [1:0] sel;
	modport arb (input pend, input grant_ok, output hit, output sel);
	modport eng (output pend, output grant_ok, input hit, input sel);
endinterface : dmx_arb_if
`default_nettype wire

// File: src/dmx_arbiter.sv
// Purpose: fixed-priority channel pick.
// Assumes: grant_ok low whenever the bus must not be taken.
// Notes: lowest channel index wins.
`default_nettype none
module dmx_arbiter (
	dmx_arb_if.arb arb_io
);
	import dmx_pkg::*;
	always_comb begin
		arb_io.hit = 1'b0;
		arb_io.sel = 2'h0;
		// Scan downward so the lowest pending index is left standing
		for (int i = DMX_NCH - 1; i >= 0; i--) begin
			if (arb_io.grant_ok && arb_io.pend[i]) begin
				arb_io.hit = 1'b1;
				arb_io.sel = 2'(i);
			end
		end
	end
endmodule : dmx_arbiter
`default_nettype wire

// File: src/dmx_unit_step.sv
// Purpose: next size and byte count after one unit transfer.
// Assumes: inputs are the registers of the channel on the bus.
// Notes: purely combinational.
`default_nettype none
module dmx_unit_step (
	input wire logic [31:0] size_cur,
	input wire logic [31:0] count_cur,
	input wire logic [1:0] dsz,
	input wire logic blk_on,
	output logic [31:0] size_nxt,
	output logic [31:0] count_nxt,
	output logic blk_end,
	output logic tot_end
);
	import dmx_pkg::*;
	logic [31:0] step;
	assign step = 32'h1 << dsz;
	always_comb begin
		count_nxt = count_cur;
		tot_end = 1'b0;
		// A zero count is never counted and never completes
		if (count_cur != 32'h0) begin
			if (count_cur <= step) begin
				count_nxt = 32'h0;
				tot_end = 1'b1;
			end else begin
				count_nxt = count_cur - step;
			end
		end
	end
	always_comb begin
		size_nxt = size_cur;
		blk_end = 1'b0;
		if (blk_on) begin
			if (size_cur[15:0] <= 16'h1) begin
				size_nxt = {size_cur[31:16], size_cur[31:16]};
				blk_end = 1'b1;
			end else begin
				size_nxt = {size_cur[31:16], size_cur[15:0] - 16'h1};
			end
		end
	end
endmodule : dmx_unit_step
`default_nettype wire

// File: test/dmx_bus_model.sv
// Purpose: bus controller model that ends each requested DMA bus phase.
// Assumes: cyc_req stays high through the read and write phases of a unit.
// Notes: wait_cyc stretches every phase to mimic slow memory.
`default_nettype none
module dmx_bus_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cyc_req,
	input wire logic [7:0] wait_cyc,
	output logic cyc_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	// Quiet cycle after each pulse so one phase is never ended twice
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			cyc_done <= 1'b0;
		end else if (cyc_done || !cyc_req) begin
			cnt <= 8'h00;
			cyc_done <= 1'b0;
		end else if (cnt >= wait_cyc) begin
			cyc_done <= 1'b1;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : dmx_bus_model
`default_nettype wire

// File: test/tb_top.sv
// Purpose: self-checking bench of channel status, flags and bus use.
// Assumes: the bus model answers every phase of every unit.
// Notes: software also clears enable while a channel runs, in the block and burst tests.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dmx_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [3:0] xfer_req = 4'h0;
	logic [3:0] esc_evt = 4'h0;
	logic nmi_evt = 1'b0;
	logic addr_err_evt = 1'b0;
	logic hw_standby = 1'b0;
	logic module_stop = 1'b0;
	logic other_req = 1'b0;
	logic [7:0] wait_cyc = 8'h03;
	logic cyc_done, cyc_req, cyc_write;
	logic [1:0] cyc_ch, cyc_size;
	logic [3:0] esc_irq, end_irq;
	logic req_q = 1'b0;
	logic [31:0] d;
	int fails = 0;
	int checks_done = 0;
	int units [4] = '{0, 0, 0, 0};
	int runs = 0;
	int n;
	always #4 core_clk = ~core_clk;
	dmx_engine u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.xfer_req(xfer_req), .esc_evt(esc_evt), .nmi_evt(nmi_evt),
		.addr_err_evt(addr_err_evt), .hw_standby(hw_standby), .module_stop(module_stop),
		.other_req(other_req), .cyc_done(cyc_done), .cyc_req(cyc_req),
		.cyc_write(cyc_write), .cyc_ch(cyc_ch), .cyc_size(cyc_size),
		.esc_irq(esc_irq), .end_irq(end_irq));
	dmx_bus_model u_bus (.core_clk(core_clk), .rst(rst), .cyc_req(cyc_req),
		.wait_cyc(wait_cyc), .cyc_done(cyc_done));
	// Counts bus grants and finished units per channel
	always @(posedge core_clk) begin
		req_q <= cyc_req;
		if (cyc_req && !req_q) runs <= runs + 1;
		if (cyc_req && cyc_write && cyc_done) units[cyc_ch] <= units[cyc_ch] + 1;
	end
	function automatic logic [7:0] ra(input int ch, input logic [3:0] o);
		return {2'b00, 2'(ch), o};
	endfunction : ra
	function automatic logic [31:0] mw(input logic en, input logic escape_interrupt_enable, input logic completion_interrupt_enable,
		input logic [1:0] xm, input logic [1:0] dsz);
		return {20'h0, dsz, xm, 1'b0, completion_interrupt_enable, 1'b0, escape_interrupt_enable, 3'b000, en};
	endfunction : mw
	task automatic print_verdict();
		if (fails == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Read data stands only in the cycle after the strobe
	task automatic chr(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		chk(nm, e, d);
	endtask : chr
	task automatic wait_for(input int ch, input int nu, input int rq);
		int k;
		k = 0;
		while ((rq < 0 ? units[ch] < nu : cyc_req !== rq[0]) && k < 2000) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		if (k >= 2000) begin
			fails++;
			print_verdict();
		end
	endtask : wait_for
	task automatic clr();
		@(posedge core_clk);
		#1;
		runs = 0;
		units = '{0, 0, 0, 0};
	endtask : clr
	initial begin
		repeat (60000) @(posedge core_clk);
		fails++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		chr("size rst", ra(0, OFS_SIZE), RST_SIZE);
		chr("count rst", ra(0, OFS_COUNT), RST_COUNT);
		wr(8'hC4, 32'hFFFF_FFFF);
		wr(ra(0, 4'hC), 32'hFFFF_FFFF);
		chr("unmapped", ra(0, 4'hC), 32'h0);
		chr("mode rst", ra(0, OFS_MODE), 32'h0);
		// Cycle steal, three bytes
		clr();
		wr(ra(0, OFS_COUNT), 32'h3);
		wr(ra(0, OFS_MODE), mw(1, 0, 1, XM_STEAL, 2'h0));
		xfer_req <= 4'h1;
		wait_for(0, 3, -1);
		repeat (5) @(posedge core_clk);
		xfer_req <= 4'h0;
		chk("steal units", 32'h3, 32'(units[0]));
		chk("steal grants", 32'h3, 32'(runs));
		chr("steal mode", ra(0, OFS_MODE), mw(0, 0, 1, XM_STEAL, 2'h0) | (32'h1 << B_COMPLETION_FLAG));
		chk("end irq", 32'h1, 32'(end_irq));
		chr("steal count", ra(0, OFS_COUNT), 32'h0);
		wr(ra(0, OFS_MODE), mw(1, 0, 1, XM_STEAL, 2'h0));
		chr("resume mode", ra(0, OFS_MODE), mw(1, 0, 1, XM_STEAL, 2'h0));
		chk("end irq off", 32'h0, 32'(end_irq));
		wr(ra(0, OFS_MODE), 32'h0);
		chr("sw stop", ra(0, OFS_MODE), 32'h0);
		// Block mode, two blocks of two words, stop written in the second
		clr();
		wr(ra(1, OFS_SIZE), 32'h0002_0002);
		wr(ra(1, OFS_COUNT), 32'h8);
		wr(ra(1, OFS_MODE), mw(1, 0, 0, XM_BLOCK, 2'h1));
		xfer_req <= 4'h2;
		wait_for(1, 1, -1);
		chk("unit size", 32'h1, 32'(cyc_size));
		chr("mid block", ra(1, OFS_SIZE), 32'h0002_0001);
		wait_for(1, 3, -1);
		wr(ra(1, OFS_MODE), mw(0, 0, 0, XM_BLOCK, 2'h1));
		chr("block act", ra(1, OFS_MODE), mw(0, 0, 0, XM_BLOCK, 2'h1) | 32'h2);
		wait_for(1, 4, -1);
		repeat (5) @(posedge core_clk);
		xfer_req <= 4'h0;
		chk("block grants", 32'h2, 32'(runs));
		chk("block units", 32'h4, 32'(units[1]));
		chr("block size", ra(1, OFS_SIZE), 32'h0002_0002);
		chr("block count", ra(1, OFS_COUNT), 32'h0);
		// Priority with another master holding the bus first
		clr();
		wait_cyc <= 8'h00;
		other_req <= 1'b1;
		wr(ra(2, OFS_COUNT), 32'h1);
		wr(ra(3, OFS_COUNT), 32'h1);
		wr(ra(3, OFS_SIZE), 32'h0004_0004);
		wr(ra(2, OFS_MODE), mw(1, 0, 0, XM_STEAL, 2'h0));
		wr(ra(3, OFS_MODE), mw(1, 0, 0, XM_REPEAT, 2'h0));
		xfer_req <= 4'hC;
		repeat (5) @(posedge core_clk);
		chk("held off", 32'h0, 32'(runs));
		other_req <= 1'b0;
		wait_for(0, 0, 1);
		chk("first ch", 32'h2, 32'(cyc_ch));
		wait_for(3, 1, -1);
		xfer_req <= 4'h0;
		chk("ch2 units", 32'h1, 32'(units[2]));
		chr("repeat size", ra(3, OFS_SIZE), 32'h0004_0003);
		// Escape in mid unit, uncounted channel
		wait_cyc <= 8'h03;
		wr(ra(0, OFS_MODE), mw(1, 1, 0, XM_STEAL, 2'h0));
		xfer_req <= 4'h1;
		wait_for(0, 0, 1);
		@(posedge core_clk);
		esc_evt <= 4'h1;
		@(posedge core_clk);
		esc_evt <= 4'h0;
		wait_for(0, 0, 0);
		repeat (4) @(posedge core_clk);
		xfer_req <= 4'h0;
		chk("esc irq", 32'h1, 32'(esc_irq));
		chr("esc mode", ra(0, OFS_MODE), mw(0, 1, 0, XM_STEAL, 2'h0) | (32'h1 << B_ESCAPE_FLAG));
		chr("esc count", ra(0, OFS_COUNT), 32'h0);
		wr(ra(0, OFS_MODE), mw(1, 1, 0, XM_STEAL, 2'h0));
		chr("esc resume", ra(0, OFS_MODE), mw(1, 1, 0, XM_STEAL, 2'h0));
		chk("esc irq off", 32'h0, 32'(esc_irq));
		// System errors, module stop and standby
		wr(ra(1, OFS_MODE), mw(1, 0, 0, XM_STEAL, 2'h0));
		@(posedge core_clk);
		module_stop <= 1'b1;
		nmi_evt <= 1'b1;
		@(posedge core_clk);
		module_stop <= 1'b0;
		nmi_evt <= 1'b0;
		chr("system_error_flag stopped", ra(0, OFS_MODE), mw(0, 1, 0, XM_STEAL, 2'h0));
		chr("nmi clears", ra(1, OFS_MODE), 32'h0);
		wr(ra(2, OFS_MODE), mw(1, 0, 0, XM_STEAL, 2'h0));
		@(posedge core_clk);
		addr_err_evt <= 1'b1;
		@(posedge core_clk);
		addr_err_evt <= 1'b0;
		chr("system_error_flag set", ra(0, OFS_MODE), mw(0, 1, 0, XM_STEAL, 2'h0) | (32'h1 << B_SYSTEM_ERROR_FLAG));
		chr("aerr clears", ra(2, OFS_MODE), 32'h0);
		wr(ra(3, OFS_MODE), mw(1, 0, 0, XM_STEAL, 2'h0));
		@(posedge core_clk);
		hw_standby <= 1'b1;
		@(posedge core_clk);
		hw_standby <= 1'b0;
		chr("standby", ra(3, OFS_MODE), 32'h0);
		wr(ra(0, OFS_MODE), 32'h0);
		// Burst stopped by software
		clr();
		wait_cyc <= 8'h00;
		wr(ra(0, OFS_MODE), mw(1, 0, 0, XM_BURST, 2'h2));
		xfer_req <= 4'h1;
		wait_for(0, 2, -1);
		wr(ra(0, OFS_MODE), mw(0, 0, 0, XM_BURST, 2'h2));
		#1;
		n = units[0];
		repeat (30) @(posedge core_clk);
		xfer_req <= 4'h0;
		chk("burst drain", 32'h1, 32'(units[0] - n <= 3));
		chk("burst grants", 32'h1, 32'(runs));
		chr("burst idle", ra(0, OFS_MODE), mw(0, 0, 0, XM_BURST, 2'h2));
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
